// *** rtl/rfs_pkg.sv ***
// Purpose: Constants for the RF setup command handler.
// Assumes: Byte-wide command stream, one clock.
package rfs_pkg;
   localparam logic [7:0] RFS_CMD_SET_LOSS = 8'h55;
   localparam logic [7:0] RFS_CMD_GET_LOSS = 8'h56;
   localparam logic [7:0] RFS_CMD_SET_ULS  = 8'h57;
   localparam logic [7:0] RFS_CMD_GET_ULS  = 8'h58;
   localparam logic [7:0] RFS_CMD_SET_FREQ = 8'h60;
   localparam logic [7:0] RFS_CR           = 8'h0D;
   localparam logic [7:0] RFS_ACK          = 8'h00;
   localparam logic [7:0] RFS_NACK         = 8'h01;
   localparam logic [7:0] RFS_LOSS_MAX     = 8'h03;
   localparam logic [1:0] RFS_LOSS_RST     = 2'h0;
   localparam logic [3:0] RFS_PROT_IAG     = 4'h2;
   localparam logic [3:0] RFS_PROT_CVISN   = 4'h3;
   localparam logic [3:0] RFS_PROT_T21     = 4'h4;
   localparam logic [3:0] RFS_PROT_ISO     = 4'h8;
   localparam int         RFS_NPROT        = 4;
   localparam int         RFS_PROT_LSB     = 4;
   localparam logic [15:0] RFS_FREQ_RST    = 16'h0198;
   localparam int         RFS_STEP_KHZ     = 250;
   localparam int         RFS_BASE_MHZ     = 800;
   localparam int         RFS_MAX_REPLY    = 4;
   localparam int         RFS_MAX_ARGS     = 3;
   typedef enum logic [2:0] {RFS_IDLE, RFS_ARGS, RFS_TAIL, RFS_EXEC, RFS_SEND} rfs_state_e;
endpackage

// *** rtl/rfs_tx.sv ***
// Purpose: Serialises a reply of up to four bytes onto a valid/ready byte port.
// Assumes: Reply bytes are held stable while busy.
// Notes: Busy from load until the last byte is taken.
`timescale 1ns/10ps
module rfs_tx
   import rfs_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       arst_n_i,
   // Load side
   input  wire logic       load_i,
   input  wire logic [2:0] len_i,
   input  wire logic [7:0] b0_i,
   input  wire logic [7:0] b1_i,
   input  wire logic [7:0] b2_i,
   input  wire logic [7:0] b3_i,
   output logic            busy_o,
   // Byte out
   output logic [7:0]      tx_data_o,
   output logic            tx_valid_o,
   input  wire logic       tx_ready_i
);
   logic [2:0] idx_q, idx_d;
   logic [2:0] len_q, len_d;
   logic       busy_q, busy_d;
   logic [7:0] data_d;

   always_comb
   begin
      idx_d  = idx_q;
      len_d  = len_q;
      busy_d = busy_q;
      if (load_i && !busy_q)
      begin
         idx_d  = 3'h0;
         len_d  = len_i;
         busy_d = 1'b1;
      end
      else if (busy_q && tx_ready_i)
      begin
         idx_d = idx_q + 3'h1;
         if (idx_q + 3'h1 == len_q)
         begin
            busy_d = 1'b0;
         end
      end
      unique case (idx_d[1:0])
         2'h0: data_d = b0_i;
         2'h1: data_d = b1_i;
         2'h2: data_d = b2_i;
         2'h3: data_d = b3_i;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         idx_q     <= 3'h0;
         len_q     <= 3'h0;
         busy_q    <= 1'b0;
         tx_data_o <= 8'h00;
      end
      else
      begin
         idx_q     <= idx_d;
         len_q     <= len_d;
         busy_q    <= busy_d;
         tx_data_o <= data_d;
      end
   end

   assign busy_o     = busy_q;
   assign tx_valid_o = busy_q;
endmodule

// *** rtl/rfs_cmd.sv ***
// Purpose: Parses RF setup command frames and holds the RF configuration.
// Assumes: Host bytes arrive on a valid/ready port synchronous to ref_clk_i.
// Notes: Unknown commands and malformed frames are dropped without reply.
`timescale 1ns/10ps
module rfs_cmd
   import rfs_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        arst_n_i,
   // Host byte in
   input  wire logic [7:0]  rx_data_i,
   input  wire logic        rx_valid_i,
   output logic             rx_ready_o,
   // Host byte out
   output logic [7:0]       tx_data_o,
   output logic             tx_valid_o,
   input  wire logic        tx_ready_i,
   // RF configuration
   output logic [1:0]       line_loss_o,
   output logic [3:0]       uls_ctrl_o [RFS_NPROT],
   output logic [RFS_NPROT-1:0] uplink_from_src1_o,
   output logic [15:0]      freq_src1_o,
   output logic [15:0]      freq_src2_o,
   output logic             freq_load_o
);
   // ------------------------------------------------------------
   // Frame parser
   // ------------------------------------------------------------
   rfs_state_e st_q, st_d;
   logic [7:0] cmd_q, cmd_d;
   logic [7:0] arg_q [RFS_MAX_ARGS];
   logic [7:0] arg_d [RFS_MAX_ARGS];
   logic [1:0] cnt_q, cnt_d;
   logic [1:0] need;
   logic       tx_busy;
   logic       rx_fire;

   assign rx_ready_o = (st_q == RFS_IDLE) || (st_q == RFS_ARGS) || (st_q == RFS_TAIL);
   assign rx_fire    = rx_valid_i && rx_ready_o;

   always_comb
   begin
      unique case (cmd_q)
         RFS_CMD_SET_LOSS: need = 2'd1;
         RFS_CMD_GET_LOSS: need = 2'd0;
         RFS_CMD_SET_ULS:  need = 2'd1;
         RFS_CMD_GET_ULS:  need = 2'd1;
         default:          need = 2'd3;
      endcase
   end

   always_comb
   begin
      st_d  = st_q;
      cmd_d = cmd_q;
      arg_d = arg_q;
      cnt_d = cnt_q;
      unique case (st_q)
         RFS_IDLE:
            if (rx_fire)
            begin
               cmd_d = rx_data_i;
               cnt_d = 2'd0;
               if (rx_data_i == RFS_CMD_GET_LOSS)
               begin
                  st_d = RFS_TAIL;
               end
               else if (rx_data_i == RFS_CMD_SET_LOSS || rx_data_i == RFS_CMD_SET_ULS ||
                        rx_data_i == RFS_CMD_GET_ULS || rx_data_i == RFS_CMD_SET_FREQ)
               begin
                  st_d = RFS_ARGS;
               end
            end
         RFS_ARGS:
            if (rx_fire)
            begin
               arg_d[cnt_q] = rx_data_i;
               cnt_d        = cnt_q + 2'd1;
               if (cnt_q + 2'd1 == need)
               begin
                  st_d = RFS_TAIL;
               end
            end
         RFS_TAIL:
            if (rx_fire)
            begin
               // A missing terminator drops the frame so the parser resyncs.
               st_d = (rx_data_i == RFS_CR) ? RFS_EXEC : RFS_IDLE;
            end
         RFS_EXEC:
            st_d = RFS_SEND;
         RFS_SEND:
            if (!tx_busy)
            begin
               st_d = RFS_IDLE;
            end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         st_q  <= RFS_IDLE;
         cmd_q <= 8'h00;
         cnt_q <= 2'd0;
         for (int i = 0; i < RFS_MAX_ARGS; i++)
         begin
            arg_q[i] <= 8'h00;
         end
      end
      else
      begin
         st_q  <= st_d;
         cmd_q <= cmd_d;
         cnt_q <= cnt_d;
         arg_q <= arg_d;
      end
   end

   // ------------------------------------------------------------
   // Configuration state and reply
   // ------------------------------------------------------------
   logic [1:0]  loss_q, loss_d;
   logic [3:0]  uls_q [RFS_NPROT];
   logic [3:0]  uls_d [RFS_NPROT];
   logic [15:0] f1_q, f1_d, f2_q, f2_d;
   logic        fld_q, fld_d;
   logic        exec;
   logic        loss_ok;
   logic [3:0]  prot;
   logic [2:0]  r_len;
   logic [7:0]  r_b1, r_b2;
   logic [7:0]  uls_rd;
   localparam logic [3:0] PROT_CODE [RFS_NPROT] =
      '{RFS_PROT_IAG, RFS_PROT_CVISN, RFS_PROT_T21, RFS_PROT_ISO};

   assign exec    = (st_q == RFS_EXEC);
   assign loss_ok = (arg_q[0] <= RFS_LOSS_MAX);
   assign prot    = arg_q[0][7:RFS_PROT_LSB];

   always_comb
   begin
      loss_d = loss_q;
      uls_d  = uls_q;
      f1_d   = f1_q;
      f2_d   = f2_q;
      fld_d  = 1'b0;
      uls_rd = {prot, 4'h0};
      r_len  = 3'd4;
      r_b1   = arg_q[0];
      r_b2   = RFS_ACK;
      for (int p = 0; p < RFS_NPROT; p++)
      begin
         if (prot == PROT_CODE[p])
         begin
            uls_rd = {prot, uls_q[p]};
            if (exec && cmd_q == RFS_CMD_SET_ULS)
            begin
               uls_d[p] = arg_q[0][3:0];
            end
         end
      end
      unique case (cmd_q)
         RFS_CMD_SET_LOSS:
         begin
            r_b2 = loss_ok ? RFS_ACK : RFS_NACK;
            if (exec && loss_ok)
            begin
               loss_d = arg_q[0][1:0];
            end
         end
         RFS_CMD_GET_LOSS:
            r_b1 = {6'h00, loss_q};
         RFS_CMD_GET_ULS:
            r_b1 = uls_rd;
         RFS_CMD_SET_FREQ:
         begin
            r_len = 3'd4;
            if (exec)
            begin
               fld_d = 1'b1;
               if (arg_q[0][0] == 1'b0)
               begin
                  f1_d = {arg_q[1], arg_q[2]};
               end
               else
               begin
                  f2_d = {arg_q[1], arg_q[2]};
               end
            end
         end
         default:
            r_b1 = arg_q[0];
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         loss_q <= RFS_LOSS_RST;
         f1_q   <= RFS_FREQ_RST;
         f2_q   <= RFS_FREQ_RST;
         fld_q  <= 1'b0;
         for (int i = 0; i < RFS_NPROT; i++)
         begin
            uls_q[i] <= 4'h0;
         end
      end
      else
      begin
         loss_q <= loss_d;
         uls_q  <= uls_d;
         f1_q   <= f1_d;
         f2_q   <= f2_d;
         fld_q  <= fld_d;
      end
   end

   // Control bit one means the uplink borrows the downlink source 1.
   genvar g;
   generate
      for (g = 0; g < RFS_NPROT; g++)
      begin : g_uls
         assign uls_ctrl_o[g]         = uls_q[g];
         assign uplink_from_src1_o[g] = uls_q[g][0];
      end
   endgenerate

   assign line_loss_o = loss_q;
   assign freq_src1_o = f1_q;
   assign freq_src2_o = f2_q;
   assign freq_load_o = fld_q;

   rfs_tx u_tx
   (
      .ref_clk_i  (ref_clk_i),
      .arst_n_i   (arst_n_i),
      .load_i     (exec),
      .len_i      (r_len),
      .b0_i       (cmd_q),
      .b1_i       (r_b1),
      .b2_i       (r_b2),
      .b3_i       (RFS_CR),
      .busy_o     (tx_busy),
      .tx_data_o  (tx_data_o),
      .tx_valid_o (tx_valid_o),
      .tx_ready_i (tx_ready_i)
   );
endmodule

// *** tb/rfs_cmd_props.sv ***
// Purpose: Concurrent checks on the RF setup command handler ports.
// Assumes: One clock domain, reset asynchronous and active low.
// Notes: Loss and frequency settings may only move while the matching reply is out.
`timescale 1ns/10ps
module rfs_cmd_props
   import rfs_pkg::*;
(
   // Clock and reset
   input wire logic        ref_clk_i,
   input wire logic        arst_n_i,
   // Host bytes
   input wire logic [7:0]  rx_data_i,
   input wire logic        rx_valid_i,
   input wire logic        rx_ready_o,
   input wire logic [7:0]  tx_data_o,
   input wire logic        tx_valid_o,
   input wire logic        tx_ready_i,
   // Settings
   input wire logic [1:0]  line_loss_o,
   input wire logic [3:0]  uls_ctrl_o [RFS_NPROT],
   input wire logic [3:0]  uplink_from_src1_o,
   input wire logic [15:0] freq_src1_o,
   input wire logic [15:0] freq_src2_o,
   input wire logic        freq_load_o
);
   // -------------------------------------------------------------
   // Properties
   // -------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);
   property p_busy; tx_valid_o |-> !rx_ready_o; endproperty
   property p_first; $rose(tx_valid_o) |-> tx_data_o inside {8'h55, 8'h56, 8'h57, 8'h58, 8'h60};
   endproperty
   property p_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o); endproperty
   property p_tail; $fell(tx_valid_o) |-> $past(tx_data_o) == RFS_CR; endproperty
   property p_loss; $changed(line_loss_o) |-> tx_valid_o && tx_data_o == RFS_CMD_SET_LOSS;
   endproperty
   property p_f1; $changed(freq_src1_o) |-> freq_load_o && tx_data_o == RFS_CMD_SET_FREQ;
   endproperty
   property p_f2; $changed(freq_src2_o) |-> freq_load_o && tx_data_o == RFS_CMD_SET_FREQ;
   endproperty
   property p_pulse; freq_load_o |=> !freq_load_o; endproperty
   property p_route; uplink_from_src1_o == {uls_ctrl_o[3][0], uls_ctrl_o[2][0],
      uls_ctrl_o[1][0], uls_ctrl_o[0][0]}; endproperty
   a_busy: assert property (p_busy) else $error("input taken during reply");
   a_first: assert property (p_first) else $error("reply opens badly");
   a_hold: assert property (p_hold) else $error("reply byte moved");
   a_tail: assert property (p_tail) else $error("reply tail wrong");
   a_loss: assert property (p_loss) else $error("loss moved");
   a_f1: assert property (p_f1) else $error("source 1 word moved");
   a_f2: assert property (p_f2) else $error("source 2 word moved");
   a_pulse: assert property (p_pulse) else $error("load pulse too long");
   a_route: assert property (p_route) else $error("uplink route wrong");
   c_load: cover property (freq_load_o);
   c_stall: cover property (tx_valid_o && !tx_ready_i);
   c_loss: cover property ($changed(line_loss_o));
endmodule
bind rfs_cmd rfs_cmd_props u_props (.ref_clk_i, .arst_n_i, .rx_data_i, .rx_valid_i,
   .rx_ready_o, .tx_data_o, .tx_valid_o, .tx_ready_i, .line_loss_o, .uls_ctrl_o,
   .uplink_from_src1_o, .freq_src1_o, .freq_src2_o, .freq_load_o);

// *** tb/rfs_host.sv ***
// Purpose: Host side that takes reply bytes.
// Assumes: Stall pattern comes from the bench.
// Notes: Stalls prove that reply bytes stand until taken.
`timescale 1ns/10ps
module rfs_host
(
   // Reply in
   input  wire logic [7:0] tx_data_i,
   input  wire logic       tx_valid_i,
   input  wire logic       stall_i,
   output logic            tx_ready_o,
   // Taken bytes
   output logic            got_vld_o,
   output logic [7:0]      got_data_o
);
   // -------------------------------------------------------------
   // Byte sink
   // -------------------------------------------------------------
   assign tx_ready_o = !stall_i;
   assign got_vld_o = tx_valid_i && tx_ready_o;
   assign got_data_o = tx_data_i;
endmodule

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for the RF setup command handler.
// Assumes: Host model stalls at random.
// Notes: An integer model gives every reply and setting.
`timescale 1ns/10ps
module testbench;
   import rfs_pkg::*;
   // -------------------------------------------------------------
   // Stimulus and model
   // -------------------------------------------------------------
   logic        ref_clk_i = 1'b0;
   logic        arst_n_i = 1'b0;
   logic [7:0]  rx_data_i = 8'h00;
   logic        rx_valid_i = 1'b0;
   logic        stall = 1'b0;
   logic        rx_ready_o, tx_valid_o, tx_ready_i, freq_load_o, got_vld;
   logic [7:0]  tx_data_o, got_data, pb;
   logic [1:0]  line_loss_o;
   logic [3:0]  uls_ctrl_o [RFS_NPROT];
   logic [3:0]  uplink_from_src1_o;
   logic [15:0] freq_src1_o, freq_src2_o, w;
   logic [31:0] rs = 32'h00017F76;
   logic [7:0]  q[$], e[$], got[$];
   int          err_total = 0, checks_done = 0, loss = 0, v, c;
   int          f1 = 16'h0198, f2 = 16'h0198;
   int          loads = 0, loads_x = 0;
   int          ctl [4] = '{0, 0, 0, 0};
   int          prot [4] = '{2, 3, 4, 8};
   rfs_cmd u_rfs_cmd (.ref_clk_i, .arst_n_i, .rx_data_i, .rx_valid_i, .rx_ready_o,
      .tx_data_o, .tx_valid_o, .tx_ready_i, .line_loss_o, .uls_ctrl_o,
      .uplink_from_src1_o, .freq_src1_o, .freq_src2_o, .freq_load_o);
   rfs_host u_rfs_host (.tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o), .stall_i(stall),
      .tx_ready_o(tx_ready_i), .got_vld_o(got_vld), .got_data_o(got_data));
   initial forever #5 ref_clk_i = ~ref_clk_i;
   always @(negedge ref_clk_i) stall <= (rnd() % 3) == 0;
   always @(posedge ref_clk_i) if (got_vld) got.push_back(got_data);
   always @(posedge ref_clk_i) if (freq_load_o === 1'b1) loads++;
   function logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   task chk(string n, logic [15:0] s, logic [15:0] x);
      checks_done++;
      if (s !== x)
      begin
         err_total++;
         $display("unexpected %s expected %h seen %h", n, x, s);
      end
   endtask
   task frame();
      foreach (q[i])
      begin
         @(negedge ref_clk_i);
         rx_data_i = q[i];
         rx_valid_i = 1'b1;
         // Ready moves only on the rising edge, so the falling edge shows what the next one takes.
         while (rx_ready_o !== 1'b1) @(negedge ref_clk_i);
         @(posedge ref_clk_i);
      end
      @(negedge ref_clk_i);
      rx_valid_i = 1'b0;
      repeat (40) if (got.size() < e.size() || e.size() == 0) @(posedge ref_clk_i);
      chk("reply length", 16'(got.size()), 16'(e.size()));
      foreach (e[i]) if (i < got.size()) chk("reply byte", got[i], e[i]);
      chk("line loss", line_loss_o, 16'(loss));
      chk("source 1 word", freq_src1_o, 16'(f1));
      chk("source 2 word", freq_src2_o, 16'(f2));
      chk("load pulses", 16'(loads), 16'(loads_x));
      foreach (ctl[p]) chk("uplink control", uls_ctrl_o[p], 16'(ctl[p]));
      foreach (ctl[p]) chk("uplink route", uplink_from_src1_o[p], 16'(ctl[p]));
      q.delete();
      e.delete();
      got.delete();
   endtask
   task print_verdict();
      if (err_total == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      #200000;
      err_total++;
      print_verdict();
   end
   initial
   begin
      repeat (8) @(negedge ref_clk_i);
      arst_n_i = 1'b1;
      frame();
      // Attenuation lives outside this block, so loss is set at once.
      for (v = 0; v < 6; v++)
      begin
         q = '{8'h55, 8'(v), 8'h0D};
         e = '{8'h55, 8'(v), (v > 3) ? 8'h01 : 8'h00, 8'h0D};
         if (v <= 3) loss = v;
         frame();
         q = '{8'h56, 8'h0D};
         e = '{8'h56, 8'(loss), 8'h00, 8'h0D};
         frame();
      end
      q = '{8'h55, 8'h01, 8'h0E};
      frame();
      // An unknown command byte must be swallowed with no reply.
      q = '{8'h59, 8'h0D};
      frame();
      for (int r = 0; r < 10; r++)
      begin
         v = r % 5;
         c = rnd() % 2;
         pb = 8'((v < 4 ? prot[v] : 5) * 16 + c);
         q = '{8'h57, pb, 8'h0D};
         e = '{8'h57, pb, 8'h00, 8'h0D};
         if (v < 4) ctl[v] = c;
         frame();
         q = '{8'h58, pb & 8'hF0, 8'h0D};
         e = '{8'h58, (pb & 8'hF0) | 8'(v < 4 ? ctl[v] : 0), 8'h00, 8'h0D};
         frame();
      end
      // The reader is taken to be in stop mode zero from here on.
      for (int r = 0; r < 6; r++)
      begin
         w = (r == 0) ? 16'h0198 : 16'(rnd());
         c = r % 2;
         q = '{8'h60, 8'(c), w[15:8], w[7:0], 8'h0D};
         e = '{8'h60, 8'(c), 8'h00, 8'h0D};
         if (c == 1) f2 = w;
         else f1 = w;
         loads_x++;
         frame();
      end
      // A reset in mid-run must bring every setting back to its reset value.
      @(negedge ref_clk_i);
      arst_n_i = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      arst_n_i = 1'b1;
      loss = 0;
      f1 = 16'h0198;
      f2 = 16'h0198;
      ctl = '{0, 0, 0, 0};
      q = '{8'h56, 8'h0D};
      e = '{8'h56, 8'h00, 8'h00, 8'h0D};
      frame();
      print_verdict();
   end
endmodule
